/* File: hdl/fir_cal_pkg.sv */
// Constants and types for the FIR coefficient and DC calibration register bank
package fir_cal_pkg;

	localparam int COEF_DEPTH = 128;
	localparam int COEF_WIDTH = 8;
	localparam int IDX_WIDTH  = 12;
	localparam int ADDR_WIDTH = 14;
	localparam int CIDX_WIDTH = 7;

	// Register indices; byte address is four times the index
	localparam logic [IDX_WIDTH-1:0] IDX_XFER       = 12'h00f;
	localparam logic [IDX_WIDTH-1:0] IDX_CAL_STATUS = 12'h010;
	localparam logic [IDX_WIDTH-1:0] IDX_CAL_HIGH   = 12'h701;
	localparam logic [IDX_WIDTH-1:0] IDX_CAL_LOW    = 12'h73b;
	localparam logic [IDX_WIDTH-1:0] IDX_COEF_X     = 12'he00;
	localparam logic [IDX_WIDTH-1:0] IDX_COEF_Y     = 12'hf00;

	localparam int XFER_BIT   = 0;
	localparam int CAL_EN_BIT = 7;

	localparam logic [COEF_WIDTH-1:0] COEF_RESET     = 8'h00;
	localparam logic [6:0]            CAL_HIGH_RSVD  = 7'h06;
	localparam logic                  CAL_HIGH_RESET = 1'h0;
	localparam logic                  CAL_LOW_RESET  = 1'h1;

	typedef logic [COEF_DEPTH-1:0][COEF_WIDTH-1:0] coef_array_t;

	typedef enum logic [6:0] {
		RGN_NONE     = 7'h01,
		RGN_XFER     = 7'h02,
		RGN_STATUS   = 7'h04,
		RGN_CAL_HIGH = 7'h08,
		RGN_CAL_LOW  = 7'h10,
		RGN_COEF_X   = 7'h20,
		RGN_COEF_Y   = 7'h40
	} region_t;

	typedef struct packed {
		logic enableHigh;
		logic enableLowN;
	} cal_ctrl_t;

	typedef struct packed {
		logic                 valid;
		logic [IDX_WIDTH-1:0] idx;
	} wr_pend_t;

	function automatic region_t decodeRegion(input logic [IDX_WIDTH-1:0] idx);
		region_t r;
		r = RGN_NONE;
		if (idx[IDX_WIDTH-1:CIDX_WIDTH] == IDX_COEF_X[IDX_WIDTH-1:CIDX_WIDTH])
			r = RGN_COEF_X;
		else if (idx[IDX_WIDTH-1:CIDX_WIDTH] == IDX_COEF_Y[IDX_WIDTH-1:CIDX_WIDTH])
			r = RGN_COEF_Y;
		else if (idx == IDX_CAL_HIGH)
			r = RGN_CAL_HIGH;
		else if (idx == IDX_CAL_LOW)
			r = RGN_CAL_LOW;
		else if (idx == IDX_XFER)
			r = RGN_XFER;
		else if (idx == IDX_CAL_STATUS)
			r = RGN_STATUS;
		return r;
	endfunction

endpackage

/* File: hdl/coef_bank.sv */
// One filter's staged and applied coefficient memories
`timescale 1ns/1ps
module coef_bank
	import fir_cal_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire logic                  wrEn,
	input  wire logic [CIDX_WIDTH-1:0] wrIdx,
	input  wire logic [COEF_WIDTH-1:0] wrData,
	input  wire logic                  xfer,
	input  wire logic [CIDX_WIDTH-1:0] rdIdx,
	output logic      [COEF_WIDTH-1:0] rdData,
	output coef_array_t                applied
);

	coef_array_t staged;
	coef_array_t next_staged;
	coef_array_t next_applied;

	always_comb
	begin
		next_staged  = staged;
		next_applied = applied;
		if (wrEn)
			next_staged[wrIdx] = wrData;
		// Filters see only what the last transfer copied
		if (xfer)
			next_applied = staged;
	end

	// Read shows the post-edge value so a write just ahead is not missed
	assign rdData = next_staged[rdIdx];

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			staged  <= {COEF_DEPTH{COEF_RESET}};
			applied <= {COEF_DEPTH{COEF_RESET}};
		end
		else if (ce)
		begin
			staged  <= next_staged;
			applied <= next_applied;
		end
	end

	chk_reset_zero: assert property (@(posedge clock)
		$fell(srst) |-> (staged == '0 && applied == '0))
		else $error("Coefficients not zero after reset");

	chk_apply_xfer: assert property (@(posedge clock) disable iff (srst)
		(xfer && ce) |=> (applied == $past(staged)))
		else $error("Transfer did not apply staged coefficients");

	chk_hold_applied: assert property (@(posedge clock) disable iff (srst)
		!(xfer && ce) |=> $stable(applied))
		else $error("Applied coefficients changed without transfer");

	cov_bank_xfer: cover property (@(posedge clock) disable iff (srst)
		wrEn && ce ##[1:20] xfer && ce);

endmodule // coef_bank

/* File: hdl/fir_coef_and_dc_cal_regs.sv */
// AHB-Lite register bank for FIR coefficients, transfer and DC calibration enables
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module fir_coef_and_dc_cal_regs
	import fir_cal_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire logic                  hsel,
	input  wire logic [ADDR_WIDTH-1:0] haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic      [31:0]           hrdata,
	output coef_array_t                coefXApplied,
	output coef_array_t                coefYApplied,
	output cal_ctrl_t                  calCtrl,
	output logic                       xferPulse
);

	wr_pend_t                  wrPend;
	wr_pend_t                  next_wrPend;
	cal_ctrl_t                 next_calCtrl;
	logic      [31:0]          next_hrdata;
	logic                      next_xferPulse;
	logic                      addrPhase;
	logic                      commit;
	logic                      doXfer;
	region_t                   wrRegion;
	region_t                   rdRegion;
	logic      [IDX_WIDTH-1:0] rdIdxFull;
	logic      [1:0]           bankWrEn;
	logic      [COEF_WIDTH-1:0] bankRdData [2];
	coef_array_t               bankApplied [2];
	logic      [COEF_WIDTH-1:0] readByte;

	// Zero wait states; a frozen clock enable stalls the bus instead
	assign hreadyout = ce;
	assign hresp     = 1'b0;

	// Only word transfers are expected; hsize is not checked
	assign addrPhase = hsel && htrans[1] && hready && ce;
	assign commit    = wrPend.valid && ce;
	assign wrRegion  = decodeRegion(wrPend.idx);
	assign rdIdxFull = haddr[ADDR_WIDTH-1:2];
	assign rdRegion  = decodeRegion(rdIdxFull);
	assign doXfer    = commit && (wrRegion == RGN_XFER) && hwdata[XFER_BIT];

	assign bankWrEn[0] = commit && (wrRegion == RGN_COEF_X);
	assign bankWrEn[1] = commit && (wrRegion == RGN_COEF_Y);

	genvar b;
	generate
		for (b = 0; b < 2; b++)
		begin : gBank
			coef_bank uBank (
				.clock   (clock),
				.srst    (srst),
				.ce      (ce),
				.wrEn    (bankWrEn[b]),
				.wrIdx   (wrPend.idx[CIDX_WIDTH-1:0]),
				.wrData  (hwdata[COEF_WIDTH-1:0]),
				.xfer    (doXfer),
				.rdIdx   (rdIdxFull[CIDX_WIDTH-1:0]),
				.rdData  (bankRdData[b]),
				.applied (bankApplied[b])
			);
		end
	endgenerate

	assign coefXApplied = bankApplied[0];
	assign coefYApplied = bankApplied[1];

	always_comb
	begin
		next_wrPend.valid = addrPhase && hwrite;
		next_wrPend.idx   = addrPhase ? rdIdxFull : wrPend.idx;
		next_calCtrl      = calCtrl;
		if (commit && wrRegion == RGN_CAL_HIGH)
			next_calCtrl.enableHigh = hwdata[CAL_EN_BIT];
		if (commit && wrRegion == RGN_CAL_LOW)
			next_calCtrl.enableLowN = hwdata[CAL_EN_BIT];
		next_xferPulse = doXfer;
	end

	// Reads see post-edge state, so back-to-back write then read agree
	always_comb
	begin
		case (rdRegion)
			RGN_COEF_X:   readByte = bankRdData[0];
			RGN_COEF_Y:   readByte = bankRdData[1];
			RGN_CAL_HIGH: readByte = {next_calCtrl.enableHigh, CAL_HIGH_RSVD};
			RGN_CAL_LOW:  readByte = {next_calCtrl.enableLowN, 7'h00};
			RGN_STATUS:   readByte = {7'h00,
				next_calCtrl.enableHigh == next_calCtrl.enableLowN};
			RGN_XFER:     readByte = 8'h00;
			RGN_NONE:     readByte = 8'h00;
			default:      readByte = 8'h00;
		endcase
		next_hrdata = hrdata;
		if (addrPhase && !hwrite)
			next_hrdata = {24'h000000, readByte};
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			wrPend     <= '0;
			calCtrl    <= '{enableHigh: CAL_HIGH_RESET, enableLowN: CAL_LOW_RESET};
			hrdata     <= 32'h00000000;
			xferPulse  <= 1'b0;
		end
		else if (ce)
		begin
			wrPend     <= next_wrPend;
			calCtrl    <= next_calCtrl;
			hrdata     <= next_hrdata;
			xferPulse  <= next_xferPulse;
		end
	end

	chk_cal_reset: assert property (@(posedge clock)
		$fell(srst) |-> (!calCtrl.enableHigh && calCtrl.enableLowN))
		else $error("Calibration enables wrong after reset");

	chk_high_write: assert property (@(posedge clock) disable iff (srst)
		(commit && wrRegion == RGN_CAL_HIGH) |=> (calCtrl.enableHigh == $past(hwdata[7])))
		else $error("Active-high enable did not take written bit");

	chk_low_write: assert property (@(posedge clock) disable iff (srst)
		(commit && wrRegion == RGN_CAL_LOW) |=> (calCtrl.enableLowN == $past(hwdata[7])))
		else $error("Active-low enable did not take written bit");

	chk_rsvd_read: assert property (@(posedge clock) disable iff (srst)
		(addrPhase && !hwrite && rdIdxFull == IDX_CAL_HIGH) |=> (hrdata[6:0] == 7'h06))
		else $error("Reserved calibration bits read wrong");

	chk_xfer_pulse: assert property (@(posedge clock) disable iff (srst)
		(doXfer) |=> (xferPulse && coefXApplied == $past(gBank[0].uBank.staged)))
		else $error("Transfer pulse or copy missing");

	// Index of the read in its data phase, so read data is checked against state
	logic                 rdPend;
	logic                 next_rdPend;
	logic [IDX_WIDTH-1:0] rdPendIdx;
	logic [IDX_WIDTH-1:0] next_rdPendIdx;

	always_comb
	begin
		next_rdPend    = addrPhase && !hwrite;
		next_rdPendIdx = addrPhase ? rdIdxFull : rdPendIdx;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			rdPend    <= 1'b0;
			rdPendIdx <= '0;
		end
		else if (ce)
		begin
			rdPend    <= next_rdPend;
			rdPendIdx <= next_rdPendIdx;
		end
	end

	chk_read_pend: assert property (@(posedge clock) disable iff (srst)
		(addrPhase && !hwrite) |=> (rdPend && rdPendIdx == $past(rdIdxFull)))
		else $error("Read tracking lost");

	chk_idle_no_read: assert property (@(posedge clock) disable iff (srst)
		(ce && !(addrPhase && !hwrite)) |=> !rdPend)
		else $error("Read tracking without a read");

	chk_rdata_upper: assert property (@(posedge clock) disable iff (srst)
		(addrPhase && !hwrite) |=> (hrdata[31:8] == 24'h000000))
		else $error("Upper read data not zero");

	chk_low_read: assert property (@(posedge clock) disable iff (srst)
		(rdPend && rdPendIdx == IDX_CAL_LOW) |-> (hrdata[7:0] == {calCtrl.enableLowN, 7'h00}))
		else $error("Active-low enable read wrong");

	chk_high_read: assert property (@(posedge clock) disable iff (srst)
		(rdPend && rdPendIdx == IDX_CAL_HIGH) |-> (hrdata[7:0] == {calCtrl.enableHigh, CAL_HIGH_RSVD}))
		else $error("Active-high enable read wrong");

	chk_xfer_read: assert property (@(posedge clock) disable iff (srst)
		(rdPend && rdPendIdx == IDX_XFER) |-> (hrdata == 32'h00000000))
		else $error("Transfer register read not zero");

	chk_status_read: assert property (@(posedge clock) disable iff (srst)
		(rdPend && rdPendIdx == IDX_CAL_STATUS)
		|-> (hrdata == {31'h00000000, calCtrl.enableHigh == calCtrl.enableLowN}))
		else $error("Status read wrong");

	chk_unmapped_read: assert property (@(posedge clock) disable iff (srst)
		(rdPend && decodeRegion(rdPendIdx) == RGN_NONE) |-> (hrdata == 32'h00000000))
		else $error("Unmapped read not zero");

	chk_coef_x_read: assert property (@(posedge clock) disable iff (srst)
		(rdPend && decodeRegion(rdPendIdx) == RGN_COEF_X)
		|-> (hrdata == {24'h000000, gBank[0].uBank.staged[rdPendIdx[CIDX_WIDTH-1:0]]}))
		else $error("Filter X coefficient read wrong");

	chk_coef_y_read: assert property (@(posedge clock) disable iff (srst)
		(rdPend && decodeRegion(rdPendIdx) == RGN_COEF_Y)
		|-> (hrdata == {24'h000000, gBank[1].uBank.staged[rdPendIdx[CIDX_WIDTH-1:0]]}))
		else $error("Filter Y coefficient read wrong");

	chk_rdata_hold: assert property (@(posedge clock) disable iff (srst)
		(ce && !(addrPhase && !hwrite)) |=> $stable(hrdata))
		else $error("Read data changed without a read");

	chk_write_no_rdata: assert property (@(posedge clock) disable iff (srst)
		(addrPhase && hwrite) |=> $stable(hrdata))
		else $error("Write disturbed read data");

	// A frozen enable must hold every piece of state
	chk_freeze_cal: assert property (@(posedge clock) disable iff (srst)
		(!ce && !srst) |=> $stable(calCtrl))
		else $error("Calibration enables moved while frozen");

	chk_freeze_rdata: assert property (@(posedge clock) disable iff (srst)
		(!ce && !srst) |=> $stable(hrdata))
		else $error("Read data moved while frozen");

	chk_freeze_pulse: assert property (@(posedge clock) disable iff (srst)
		(!ce && !srst) |=> $stable(xferPulse))
		else $error("Transfer pulse moved while frozen");

	chk_freeze_pend: assert property (@(posedge clock) disable iff (srst)
		(!ce && !srst) |=> $stable(wrPend))
		else $error("Pending write moved while frozen");

	chk_freeze_applied: assert property (@(posedge clock) disable iff (srst)
		(!ce && !srst) |=> ($stable(coefXApplied) && $stable(coefYApplied)))
		else $error("Applied coefficients moved while frozen");

	chk_cal_hold: assert property (@(posedge clock) disable iff (srst)
		(ce && !(commit && (wrRegion == RGN_CAL_HIGH || wrRegion == RGN_CAL_LOW)))
		|=> $stable(calCtrl))
		else $error("Calibration enables changed without a write");

	chk_xfer_cal_stable: assert property (@(posedge clock) disable iff (srst)
		doXfer |=> $stable(calCtrl))
		else $error("Transfer disturbed calibration enables");

	chk_pulse_cause: assert property (@(posedge clock) disable iff (srst)
		(xferPulse && $past(ce)) |-> $past(doXfer))
		else $error("Transfer pulse without a transfer write");

	chk_pulse_once: assert property (@(posedge clock) disable iff (srst)
		(xferPulse && ce && !doXfer) |=> !xferPulse)
		else $error("Transfer pulse stood too long");

	chk_no_xfer_zero: assert property (@(posedge clock) disable iff (srst)
		(commit && wrRegion == RGN_XFER && !hwdata[XFER_BIT]) |=> !xferPulse)
		else $error("Transfer fired with bit clear");

	chk_y_copy: assert property (@(posedge clock) disable iff (srst)
		doXfer |=> (coefYApplied == $past(gBank[1].uBank.staged)))
		else $error("Filter Y copy missing");

	chk_x_hold: assert property (@(posedge clock) disable iff (srst)
		(ce && !doXfer) |=> $stable(coefXApplied))
		else $error("Filter X applied changed without transfer");

	chk_y_hold: assert property (@(posedge clock) disable iff (srst)
		(ce && !doXfer) |=> $stable(coefYApplied))
		else $error("Filter Y applied changed without transfer");

	chk_staged_x_write: assert property (@(posedge clock) disable iff (srst)
		bankWrEn[0] |=> (gBank[0].uBank.staged[$past(wrPend.idx[CIDX_WIDTH-1:0])]
		== $past(hwdata[COEF_WIDTH-1:0])))
		else $error("Filter X write did not land");

	chk_staged_y_write: assert property (@(posedge clock) disable iff (srst)
		bankWrEn[1] |=> (gBank[1].uBank.staged[$past(wrPend.idx[CIDX_WIDTH-1:0])]
		== $past(hwdata[COEF_WIDTH-1:0])))
		else $error("Filter Y write did not land");

	chk_wr_pend: assert property (@(posedge clock) disable iff (srst)
		(addrPhase && hwrite) |=> (wrPend.valid && wrPend.idx == $past(rdIdxFull)))
		else $error("Write address phase not captured");

	chk_no_pend: assert property (@(posedge clock) disable iff (srst)
		(ce && !(addrPhase && hwrite)) |=> !wrPend.valid)
		else $error("Pending write without address phase");

	chk_pend_idx_hold: assert property (@(posedge clock) disable iff (srst)
		(ce && !addrPhase) |=> (wrPend.idx == $past(wrPend.idx)))
		else $error("Pending index moved while idle");

	chk_reset_rdata: assert property (@(posedge clock)
		$fell(srst) |-> (hrdata == 32'h00000000 && !xferPulse && !wrPend.valid))
		else $error("Bus state not clear after reset");

	chk_reset_applied: assert property (@(posedge clock)
		$fell(srst) |-> (coefXApplied == '0 && coefYApplied == '0))
		else $error("Applied coefficients not zero after reset");

	cov_freeze: cover property (@(posedge clock) disable iff (srst)
		!ce ##1 ce);
	cov_cal_enable: cover property (@(posedge clock) disable iff (srst)
		calCtrl.enableHigh && !calCtrl.enableLowN);
	cov_coef_write: cover property (@(posedge clock) disable iff (srst)
		bankWrEn[1] ##1 addrPhase && !hwrite);
	cov_xfer: cover property (@(posedge clock) disable iff (srst) doXfer);

endmodule // fir_coef_and_dc_cal_regs

/* File: bench/fir_coef_and_dc_cal_regs_tb.sv */
// Self-checking bench for the FIR coefficient and DC calibration register bank
`timescale 1ns/1ps
module fir_coef_and_dc_cal_regs_tb
	import fir_cal_pkg::*;
;
	logic                  clock;
	logic                  srst;
	logic                  ce;
	logic                  hsel;
	logic [ADDR_WIDTH-1:0] haddr;
	logic [1:0]            htrans;
	logic                  hwrite;
	logic [2:0]            hsize;
	logic [31:0]           hwdata;
	logic                  hreadyout;
	logic                  hresp;
	logic [31:0]           hrdata;
	coef_array_t           coefXApplied;
	coef_array_t           coefYApplied;
	cal_ctrl_t             calCtrl;
	logic                  xferPulse;
	int                    num_errors;
	int                    checks_done;

	fir_coef_and_dc_cal_regs dut (.clock(clock), .srst(srst), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.coefXApplied(coefXApplied), .coefYApplied(coefYApplied), .calCtrl(calCtrl),
		.xferPulse(xferPulse));

	always #50 clock = ~clock;

	task automatic finish_test();
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask

	// Address phase held until hready, then data phase held until hready again
	task automatic xfer(input logic [IDX_WIDTH-1:0] idx, input logic wr, input logic [7:0] d,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= {idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [IDX_WIDTH-1:0] idx, input logic [7:0] d);
		logic [31:0] unused;
		xfer(idx, 1'b1, d, unused);
	endtask

	task automatic rdChk(input logic [IDX_WIDTH-1:0] idx, input logic [7:0] exp);
		logic [31:0] got;
		xfer(idx, 1'b0, 8'h00, got);
		chk(got, {24'h000000, exp});
	endtask

	// Applied copies of both filters at the two end entries
	task automatic appliedChk(input logic [7:0] x0, input logic [7:0] x1,
		input logic [7:0] y0, input logic [7:0] y1);
		chk({24'h0, coefXApplied[0]}, {24'h0, x0});
		chk({24'h0, coefXApplied[127]}, {24'h0, x1});
		chk({24'h0, coefYApplied[0]}, {24'h0, y0});
		chk({24'h0, coefYApplied[127]}, {24'h0, y1});
	endtask

	initial
	begin
		repeat (2000) @(posedge clock);
		num_errors++;
		finish_test();
	end

	initial
	begin
		clock = 1'b0; srst = 1'b1; ce = 1'b1; hsel = 1'b0; haddr = '0;
		htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
		num_errors = 0; checks_done = 0;
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1 chk({30'h0, calCtrl}, 32'h1);
		appliedChk(8'h00, 8'h00, 8'h00, 8'h00);
		@(posedge clock);
		rdChk(IDX_CAL_HIGH, 8'h06);
		rdChk(IDX_CAL_LOW, 8'h80);
		rdChk(IDX_CAL_STATUS, 8'h00);
		rdChk(IDX_COEF_X + 12'h07f, 8'h00);
		rdChk(IDX_COEF_Y, 8'h00);
		// Back-to-back writes then reads of both array ends
		wr(IDX_COEF_X, 8'ha5);
		wr(IDX_COEF_X + 12'h07f, 8'h5a);
		wr(IDX_COEF_Y, 8'h3c);
		wr(IDX_COEF_Y + 12'h07f, 8'hc3);
		rdChk(IDX_COEF_X, 8'ha5);
		rdChk(IDX_COEF_X + 12'h07f, 8'h5a);
		rdChk(IDX_COEF_Y, 8'h3c);
		rdChk(IDX_COEF_Y + 12'h07f, 8'hc3);
		wr(IDX_XFER, 8'hfe);
		#1 chk({31'h0, xferPulse}, 32'h0);
		appliedChk(8'h00, 8'h00, 8'h00, 8'h00);
		@(posedge clock);
		wr(IDX_XFER, 8'h01);
		#1 chk({31'h0, xferPulse}, 32'h1);
		appliedChk(8'ha5, 8'h5a, 8'h3c, 8'hc3);
		@(posedge clock);
		wr(IDX_COEF_X, 8'h11);
		#1 appliedChk(8'ha5, 8'h5a, 8'h3c, 8'hc3);
		@(posedge clock);
		// Enable: high set first, status read, then low cleared
		wr(IDX_CAL_HIGH, 8'hff);
		rdChk(IDX_CAL_STATUS, 8'h01);
		wr(IDX_CAL_LOW, 8'h00);
		#1 chk({30'h0, calCtrl}, 32'h2);
		@(posedge clock);
		rdChk(IDX_CAL_HIGH, 8'h86);
		rdChk(IDX_CAL_LOW, 8'h00);
		wr(IDX_CAL_LOW, 8'hff);
		wr(IDX_CAL_HIGH, 8'h01);
		rdChk(IDX_CAL_HIGH, 8'h06);
		rdChk(IDX_CAL_LOW, 8'h80);
		// Unmapped index: write dropped, read zero
		wr(12'h200, 8'hff);
		rdChk(12'h200, 8'h00);
		ce <= 1'b0;
		@(posedge clock);
		#1 chk({31'h0, hreadyout}, 32'h0);
		@(posedge clock);
		ce <= 1'b1;
		wr(IDX_CAL_HIGH, 8'h80);
		wr(IDX_CAL_LOW, 8'h00);
		// Second reset mid-run clears applied values and enables
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1 chk({30'h0, calCtrl}, 32'h1);
		appliedChk(8'h00, 8'h00, 8'h00, 8'h00);
		@(posedge clock);
		rdChk(IDX_COEF_X, 8'h00);
		finish_test();
	end
endmodule // fir_coef_and_dc_cal_regs_tb
